/* File: src/time_clock_control.sv */
// Overview of operation
// - Control bit 15 set stops switch timers, shapers and policers following clock trims.
// - Writing 1 to bit 6 steps the running clock by the time value, then the bit clears.
// - Bit 5 selects the step sense: 1 adds the time value, 0 subtracts it.
// - Writing 1 to bit 4 copies the running clock into the time registers, then clears.
// - Writing 1 to bit 3 loads the running clock from the time registers, then clears.
// - While bit 2 is 1 the fractional rate is applied on every 25 MHz tick.
// - Bit 1 lets the clock advance when 1 and holds it when 0.
// - Writing 1 to bit 0 zeroes the running seconds and nanoseconds, keeping the phase, then the bit clears.
// - The rate direction bit adds the fractional rate when 1 and subtracts it when 0.
// - The phase field names one of five 8 ns sub-phases; codes above 4 are invalid.
`timescale 1ns/10ps

module time_clock_control (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [ptp_clock_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ptp_clock_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [ptp_clock_pkg::DATA_W-1:0] rdata_o,
    output logic [ptp_clock_pkg::TIME_W-1:0] rtc_sec_o,
    output logic [ptp_clock_pkg::TIME_W-1:0] rtc_ns_o,
    output logic [ptp_clock_pkg::PHASE_W-1:0] rtc_phase_o,
    output logic freq_follow_disable_o,
    output logic freq_trim_o,
    output logic freq_trim_dir_o
);
    import ptp_clock_pkg::*;

    ////////////////////////////////////////////////////////////////////////////

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [ADDR_W-1:0] offset);
        reg_hit = (addr == offset);
    endfunction : reg_hit

    logic freq_off_reg, freq_off_next;
    logic step_dir_reg, step_dir_next;
    logic cont_adj_reg, cont_adj_next;
    logic clk_en_reg, clk_en_next;
    logic step_cmd_reg, step_cmd_next;
    logic snap_cmd_reg, snap_cmd_next;
    logic load_cmd_reg, load_cmd_next;
    logic clr_cmd_reg, clr_cmd_next;
    logic [PHASE_W-1:0] phase_reg, phase_next;
    logic [DATA_W-1:0] ns_hi_reg, ns_hi_next;
    logic [DATA_W-1:0] ns_lo_reg, ns_lo_next;
    logic [DATA_W-1:0] sec_hi_reg, sec_hi_next;
    logic [DATA_W-1:0] sec_lo_reg, sec_lo_next;
    logic [DATA_W-1:0] rate_hi_reg, rate_hi_next;
    logic [DATA_W-1:0] rate_lo_reg, rate_lo_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic trim_out_reg, trim_out_next;
    logic trim_dir_reg, trim_dir_next;

    logic [PHASE_W-1:0] core_phase;
    logic [TIME_W-1:0] core_sec;
    logic [TIME_W-1:0] core_ns;
    logic core_trim;
    logic [DATA_W-1:0] ctrl_word;

    ////////////////////////////////////////////////////////////////////////////

    rtc_time_core u_core (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .enable_i(clk_en_reg),
        .adj_enable_i(cont_adj_reg),
        .rate_dir_i(rate_hi_reg[RATE_DIR_BIT]),
        .rate_i({rate_hi_reg[RATE_HI_W-1:0], rate_lo_reg}),
        .clear_i(clr_cmd_reg),
        .load_i(load_cmd_reg),
        .step_i(step_cmd_reg),
        .step_add_i(step_dir_reg),
        .set_phase_i(phase_reg),
        .set_sec_i({sec_hi_reg, sec_lo_reg}),
        .set_ns_i({ns_hi_reg, ns_lo_reg}),
        .phase_o(core_phase),
        .sec_o(core_sec),
        .ns_o(core_ns),
        .trim_o(core_trim)
    );

    ////////////////////////////////////////////////////////////////////////////

    // Command bits read back as 1 only in the cycle in which they act.
    always_comb begin
        ctrl_word = ZERO_WORD;
        ctrl_word[FREQ_OFF_BIT] = freq_off_reg;
        ctrl_word[STEP_BIT] = step_cmd_reg;
        ctrl_word[STEP_DIR_BIT] = step_dir_reg;
        ctrl_word[SNAP_BIT] = snap_cmd_reg;
        ctrl_word[LOAD_BIT] = load_cmd_reg;
        ctrl_word[CONT_ADJ_BIT] = cont_adj_reg;
        ctrl_word[CLK_EN_BIT] = clk_en_reg;
        ctrl_word[CLR_BIT] = clr_cmd_reg;
    end

    // Control register and its self-clearing commands.
    always_comb begin
        logic ctrl_wr;
        ctrl_wr = wr_i && reg_hit(addr_i, CTRL_ADDR);
        freq_off_next = freq_off_reg;
        step_dir_next = step_dir_reg;
        cont_adj_next = cont_adj_reg;
        clk_en_next = clk_en_reg;
        step_cmd_next = 1'b0;
        snap_cmd_next = 1'b0;
        load_cmd_next = 1'b0;
        clr_cmd_next = 1'b0;
        if (ctrl_wr) begin
            freq_off_next = wdata_i[FREQ_OFF_BIT];
            step_dir_next = wdata_i[STEP_DIR_BIT];
            cont_adj_next = wdata_i[CONT_ADJ_BIT];
            clk_en_next = wdata_i[CLK_EN_BIT];
            step_cmd_next = wdata_i[STEP_BIT];
            snap_cmd_next = wdata_i[SNAP_BIT];
            load_cmd_next = wdata_i[LOAD_BIT];
            clr_cmd_next = wdata_i[CLR_BIT];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            freq_off_reg <= 1'b0;
            step_dir_reg <= 1'b0;
            cont_adj_reg <= 1'b0;
            clk_en_reg <= 1'b0;
            step_cmd_reg <= 1'b0;
            snap_cmd_reg <= 1'b0;
            load_cmd_reg <= 1'b0;
            clr_cmd_reg <= 1'b0;
        end else begin
            freq_off_reg <= freq_off_next;
            step_dir_reg <= step_dir_next;
            cont_adj_reg <= cont_adj_next;
            clk_en_reg <= clk_en_next;
            step_cmd_reg <= step_cmd_next;
            snap_cmd_reg <= snap_cmd_next;
            load_cmd_reg <= load_cmd_next;
            clr_cmd_reg <= clr_cmd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Time and rate registers; a snapshot wins over a software write.
    always_comb begin
        phase_next = phase_reg;
        ns_hi_next = ns_hi_reg;
        ns_lo_next = ns_lo_reg;
        sec_hi_next = sec_hi_reg;
        sec_lo_next = sec_lo_reg;
        rate_hi_next = rate_hi_reg;
        rate_lo_next = rate_lo_reg;
        if (wr_i) begin
            if (reg_hit(addr_i, PHASE_ADDR) && wdata_i[PHASE_W-1:0] <= PHASE_MAX) begin
                phase_next = wdata_i[PHASE_W-1:0];
            end
            if (reg_hit(addr_i, NS_HI_ADDR)) begin
                ns_hi_next = wdata_i;
            end
            if (reg_hit(addr_i, NS_LO_ADDR)) begin
                ns_lo_next = wdata_i;
            end
            if (reg_hit(addr_i, SEC_HI_ADDR)) begin
                sec_hi_next = wdata_i;
            end
            if (reg_hit(addr_i, SEC_LO_ADDR)) begin
                sec_lo_next = wdata_i;
            end
            if (reg_hit(addr_i, RATE_HI_ADDR)) begin
                rate_hi_next = wdata_i;
            end
            if (reg_hit(addr_i, RATE_LO_ADDR)) begin
                rate_lo_next = wdata_i;
            end
        end
        if (snap_cmd_reg) begin
            phase_next = core_phase;
            ns_hi_next = core_ns[TIME_W-1:DATA_W];
            ns_lo_next = core_ns[DATA_W-1:0];
            sec_hi_next = core_sec[TIME_W-1:DATA_W];
            sec_lo_next = core_sec[DATA_W-1:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            phase_reg <= '0;
            ns_hi_reg <= ZERO_WORD;
            ns_lo_reg <= ZERO_WORD;
            sec_hi_reg <= ZERO_WORD;
            sec_lo_reg <= ZERO_WORD;
            rate_hi_reg <= ZERO_WORD;
            rate_lo_reg <= ZERO_WORD;
        end else begin
            phase_reg <= phase_next;
            ns_hi_reg <= ns_hi_next;
            ns_lo_reg <= ns_lo_next;
            sec_hi_reg <= sec_hi_next;
            sec_lo_reg <= sec_lo_next;
            rate_hi_reg <= rate_hi_next;
            rate_lo_reg <= rate_lo_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////

    // Read data stand in the cycle after the strobe only; unmapped reads give zero.
    always_comb begin
        rdata_next = ZERO_WORD;
        if (rd_i) begin
            unique case (addr_i)
                CTRL_ADDR: rdata_next = ctrl_word;
                PHASE_ADDR: rdata_next = {{(DATA_W - PHASE_W){1'b0}}, phase_reg};
                NS_HI_ADDR: rdata_next = ns_hi_reg;
                NS_LO_ADDR: rdata_next = ns_lo_reg;
                SEC_HI_ADDR: rdata_next = sec_hi_reg;
                SEC_LO_ADDR: rdata_next = sec_lo_reg;
                RATE_HI_ADDR: rdata_next = rate_hi_reg;
                RATE_LO_ADDR: rdata_next = rate_lo_reg;
                default: rdata_next = ZERO_WORD;
            endcase
        end
    end

    // Trims reach the switch timers only while they follow the clock.
    always_comb begin
        trim_out_next = core_trim && !freq_off_reg;
        trim_dir_next = rate_hi_reg[RATE_DIR_BIT];
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            rdata_reg <= ZERO_WORD;
            trim_out_reg <= 1'b0;
            trim_dir_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            trim_out_reg <= trim_out_next;
            trim_dir_reg <= trim_dir_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rtc_sec_o = core_sec;
    assign rtc_ns_o = core_ns;
    assign rtc_phase_o = core_phase;
    assign freq_follow_disable_o = freq_off_reg;
    assign freq_trim_o = trim_out_reg;
    assign freq_trim_dir_o = trim_dir_reg;

endmodule : time_clock_control

/* File: src/ptp_clock_pkg.sv */
package ptp_clock_pkg;

    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned TIME_W = 32;
    localparam int unsigned FRAC_W = 30;
    localparam int unsigned PHASE_W = 3;
    localparam int unsigned RATE_HI_W = FRAC_W - DATA_W;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 16'h0500;
    localparam logic [ADDR_W-1:0] PHASE_ADDR = 16'h0502;
    localparam logic [ADDR_W-1:0] NS_HI_ADDR = 16'h0504;
    localparam logic [ADDR_W-1:0] NS_LO_ADDR = 16'h0506;
    localparam logic [ADDR_W-1:0] SEC_HI_ADDR = 16'h0508;
    localparam logic [ADDR_W-1:0] SEC_LO_ADDR = 16'h050a;
    localparam logic [ADDR_W-1:0] RATE_HI_ADDR = 16'h050c;
    localparam logic [ADDR_W-1:0] RATE_LO_ADDR = 16'h050e;

    // Control register bit positions.
    localparam int unsigned FREQ_OFF_BIT = 15;
    localparam int unsigned STEP_BIT = 6;
    localparam int unsigned STEP_DIR_BIT = 5;
    localparam int unsigned SNAP_BIT = 4;
    localparam int unsigned LOAD_BIT = 3;
    localparam int unsigned CONT_ADJ_BIT = 2;
    localparam int unsigned CLK_EN_BIT = 1;
    localparam int unsigned CLR_BIT = 0;

    // Rate high word bit positions.
    localparam int unsigned RATE_DIR_BIT = 15;
    localparam int unsigned RATE_TEMP_BIT = 14;

    localparam logic [DATA_W-1:0] ZERO_WORD = 16'h0000;
    localparam logic [PHASE_W-1:0] PHASE_MAX = 3'h4;

    // Timing of the real time clock.
    localparam int unsigned SYS_CLK_MHZ = 100;
    localparam int unsigned RTC_TICK_MHZ = 25;
    localparam int unsigned TICK_DIV = SYS_CLK_MHZ / RTC_TICK_MHZ;
    localparam int unsigned TICK_CNT_W = $clog2(TICK_DIV);
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_DIV - 1);
    localparam logic [TIME_W-1:0] RTC_PERIOD_NS = 32'h0000_0028;
    localparam logic [TIME_W-1:0] NS_PER_SEC = 32'h3b9a_ca00;

endpackage : ptp_clock_pkg

/* File: src/rtc_time_core.sv */
`timescale 1ns/10ps

module rtc_time_core (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic enable_i,
    input wire logic adj_enable_i,
    input wire logic rate_dir_i,
    input wire logic [ptp_clock_pkg::FRAC_W-1:0] rate_i,
    input wire logic clear_i,
    input wire logic load_i,
    input wire logic step_i,
    input wire logic step_add_i,
    input wire logic [ptp_clock_pkg::PHASE_W-1:0] set_phase_i,
    input wire logic [ptp_clock_pkg::TIME_W-1:0] set_sec_i,
    input wire logic [ptp_clock_pkg::TIME_W-1:0] set_ns_i,
    output logic [ptp_clock_pkg::PHASE_W-1:0] phase_o,
    output logic [ptp_clock_pkg::TIME_W-1:0] sec_o,
    output logic [ptp_clock_pkg::TIME_W-1:0] ns_o,
    output logic trim_o
);
    import ptp_clock_pkg::*;

    logic [TICK_CNT_W-1:0] div_reg, div_next;
    logic [PHASE_W-1:0] phase_reg, phase_next;
    logic [TIME_W-1:0] sec_reg, sec_next;
    logic [TIME_W-1:0] ns_reg, ns_next;
    logic [FRAC_W-1:0] frac_reg, frac_next;
    logic trim_reg, trim_next;

    // Seconds, nanoseconds and fraction change together in one cycle; the phase changes only on a load.
    always_comb begin
        logic [FRAC_W:0] frac_sum;
        logic [TIME_W:0] ns_sum;
        logic [TIME_W-1:0] inc;
        frac_sum = '0;
        ns_sum = '0;
        inc = RTC_PERIOD_NS;
        div_next = div_reg;
        phase_next = phase_reg;
        sec_next = sec_reg;
        ns_next = ns_reg;
        frac_next = frac_reg;
        trim_next = 1'b0;
        if (clear_i) begin
            div_next = '0;
            sec_next = '0;
            ns_next = '0;
            frac_next = '0;
        end else if (load_i) begin
            phase_next = set_phase_i;
            sec_next = set_sec_i;
            ns_next = set_ns_i;
        end else if (step_i) begin
            if (step_add_i) begin
                ns_sum = {1'b0, ns_reg} + {1'b0, set_ns_i};
                if (ns_sum >= {1'b0, NS_PER_SEC}) begin
                    ns_next = TIME_W'(ns_sum - {1'b0, NS_PER_SEC});
                    sec_next = sec_reg + set_sec_i + 32'h0000_0001;
                end else begin
                    ns_next = ns_sum[TIME_W-1:0];
                    sec_next = sec_reg + set_sec_i;
                end
            end else if (ns_reg >= set_ns_i) begin
                ns_next = ns_reg - set_ns_i;
                sec_next = sec_reg - set_sec_i;
            end else begin
                ns_next = ns_reg + NS_PER_SEC - set_ns_i;
                sec_next = sec_reg - set_sec_i - 32'h0000_0001;
            end
        end else if (enable_i) begin
            div_next = (div_reg == TICK_LAST) ? '0 : div_reg + 1'b1;
            if (div_reg == TICK_LAST) begin
                if (adj_enable_i) begin
                    if (rate_dir_i) begin
                        frac_sum = {1'b0, frac_reg} + {1'b0, rate_i};
                        inc = frac_sum[FRAC_W] ? RTC_PERIOD_NS + 32'h0000_0001 : RTC_PERIOD_NS;
                    end else begin
                        frac_sum = {1'b0, frac_reg} - {1'b0, rate_i};
                        inc = frac_sum[FRAC_W] ? RTC_PERIOD_NS - 32'h0000_0001 : RTC_PERIOD_NS;
                    end
                    frac_next = frac_sum[FRAC_W-1:0];
                    trim_next = frac_sum[FRAC_W];
                end
                ns_sum = {1'b0, ns_reg} + {1'b0, inc};
                if (ns_sum >= {1'b0, NS_PER_SEC}) begin
                    ns_next = TIME_W'(ns_sum - {1'b0, NS_PER_SEC});
                    sec_next = sec_reg + 32'h0000_0001;
                end else begin
                    ns_next = ns_sum[TIME_W-1:0];
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            div_reg <= '0;
            phase_reg <= '0;
            sec_reg <= '0;
            ns_reg <= '0;
            frac_reg <= '0;
            trim_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            phase_reg <= phase_next;
            sec_reg <= sec_next;
            ns_reg <= ns_next;
            frac_reg <= frac_next;
            trim_reg <= trim_next;
        end
    end

    assign phase_o = phase_reg;
    assign sec_o = sec_reg;
    assign ns_o = ns_reg;
    assign trim_o = trim_reg;

endmodule : rtc_time_core

/* File: sim/time_clock_control_chk.sv */
`timescale 1ns/10ps

module time_clock_control_chk (
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [ptp_clock_pkg::ADDR_W-1:0] addr_i,
    input wire logic [ptp_clock_pkg::DATA_W-1:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [ptp_clock_pkg::DATA_W-1:0] rdata_o,
    input wire logic [ptp_clock_pkg::TIME_W-1:0] rtc_sec_o,
    input wire logic [ptp_clock_pkg::TIME_W-1:0] rtc_ns_o,
    input wire logic [ptp_clock_pkg::PHASE_W-1:0] rtc_phase_o,
    input wire logic freq_follow_disable_o,
    input wire logic freq_trim_o,
    input wire logic freq_trim_dir_o
);
    import ptp_clock_pkg::*;
    logic ctl_wr;
    logic en_reg;
    logic en_next;
    logic [1:0] calm_reg;
    logic [1:0] calm_next;
    assign ctl_wr = wr_i && (addr_i == CTRL_ADDR);
    // Tracks the enable bit and how long since the last control write.
    always_comb begin
        en_next = en_reg;
        calm_next = (calm_reg == 2'h3) ? calm_reg : calm_reg + 2'h1;
        if (ctl_wr) begin
            en_next = wdata_i[CLK_EN_BIT];
            calm_next = 2'h0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            en_reg <= 1'b0;
            calm_reg <= 2'h0;
        end else begin
            en_reg <= en_next;
            calm_reg <= calm_next;
        end
    end
    ////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    sequence ctl_write;
        ctl_wr;
    endsequence
    sequence ctl_read_late;
        !ctl_wr ##1 (rd_i && addr_i == CTRL_ADDR);
    endsequence
    property reset_p;
        disable iff (1'b0) srst_i |=> (rtc_sec_o == 32'h0 && rtc_ns_o == 32'h0
            && rtc_phase_o == 3'h0 && !freq_follow_disable_o && !freq_trim_o);
    endproperty
    chk_reset_clean: assert property (reset_p)
        else $error("outputs not cleared by reset");
    chk_follow_bit: assert property (ctl_wr |=> freq_follow_disable_o == $past(wdata_i[15]))
        else $error("follow disable does not track control bit");
    chk_trim_gated: assert property (freq_follow_disable_o && $past(freq_follow_disable_o)
        && $past(freq_follow_disable_o, 2) |-> !freq_trim_o)
        else $error("trim pulse while following disabled");
    chk_trim_pulse: assert property (freq_trim_o |=> !freq_trim_o)
        else $error("trim pulse longer than one cycle");
    chk_clear_time: assert property (ctl_wr && wdata_i[CLR_BIT] |-> ##3
        (rtc_sec_o == 32'h0 && rtc_ns_o == 32'h0))
        else $error("clock not cleared by reset command");
    chk_hold_off: assert property (calm_reg == 2'h3 && !en_reg |=>
        $stable(rtc_ns_o) && $stable(rtc_sec_o))
        else $error("clock moved while disabled");
    chk_tick_run: assert property ((en_reg && calm_reg == 2'h3) [*5] |->
        rtc_ns_o != $past(rtc_ns_o, 4))
        else $error("clock did not advance while enabled");
    chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
        else $error("read data outside read slot");
    chk_ctrl_selfclr: assert property (ctl_write ##1 ctl_read_late |=>
        rdata_o == ($past(wdata_i, 3) & 16'h8026))
        else $error("control read back wrong");
    chk_trim_dir: assert property (wr_i && addr_i == RATE_HI_ADDR |-> ##2
        freq_trim_dir_o == $past(wdata_i[RATE_DIR_BIT], 2))
        else $error("trim direction does not track rate direction");
    chk_phase_range: assert property (rtc_phase_o <= PHASE_MAX)
        else $error("phase code out of range");
endmodule : time_clock_control_chk

bind time_clock_control time_clock_control_chk u_time_clock_control_chk (.clock_i(clock_i),
    .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rtc_sec_o(rtc_sec_o), .rtc_ns_o(rtc_ns_o), .rtc_phase_o(rtc_phase_o),
    .freq_follow_disable_o(freq_follow_disable_o), .freq_trim_o(freq_trim_o),
    .freq_trim_dir_o(freq_trim_dir_o));

/* File: sim/tb.sv */
`timescale 1ns/10ps

module tb;
    import ptp_clock_pkg::*;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [ADDR_W-1:0] addr_i = '0;
    logic [DATA_W-1:0] wdata_i = '0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic [TIME_W-1:0] rtc_sec_o, rtc_ns_o, esec, ens, dsec, dns, v;
    logic [PHASE_W-1:0] rtc_phase_o, eph;
    logic freq_follow_disable_o, freq_trim_o, freq_trim_dir_o;
    logic [31:0] seed = 32'h08119023;
    logic [ADDR_W-1:0] map_a [8];
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    int n;

    always #5 clock_i = ~clock_i;

    time_clock_control u_time_clock_control (.clock_i(clock_i), .srst_i(srst_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .rtc_sec_o(rtc_sec_o), .rtc_ns_o(rtc_ns_o), .rtc_phase_o(rtc_phase_o),
        .freq_follow_disable_o(freq_follow_disable_o), .freq_trim_o(freq_trim_o),
        .freq_trim_dir_o(freq_trim_dir_o));
    ////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04c11db7 : 32'h0);
        return seed;
    endfunction : rnd
    function automatic logic [63:0] step_calc(input logic [31:0] s, n, ds, dn, input logic add);
        logic [31:0] t;
        t = n + dn;
        if (add) return (t >= NS_PER_SEC) ? {s + ds + 32'h1, t - NS_PER_SEC} : {s + ds, t};
        return (n >= dn) ? {s - ds, n - dn} : {s - ds - 32'h1, n + NS_PER_SEC - dn};
    endfunction : step_calc
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clock_i);
        wr_i <= 1'b0;
        @(posedge clock_i);
    endtask : wr
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        check(rdata_o, e);
        @(posedge clock_i);
    endtask : rdc
    task automatic set_time(input logic [2:0] p, input logic [31:0] s, input logic [31:0] t);
        wr(PHASE_ADDR, {13'h0, p});
        wr(NS_HI_ADDR, t[31:16]);
        wr(NS_LO_ADDR, t[15:0]);
        wr(SEC_HI_ADDR, s[31:16]);
        wr(SEC_LO_ADDR, s[15:0]);
    endtask : set_time
    task automatic chk_rtc(input logic [31:0] s, input logic [31:0] t, input logic [2:0] p);
        @(posedge clock_i);
        @(negedge clock_i);
        check(rtc_sec_o, s);
        check(rtc_ns_o, t);
        check(rtc_phase_o, p);
        @(posedge clock_i);
    endtask : chk_rtc
    task automatic count_trims(output int k);
        k = 0;
        repeat (64) begin
            @(negedge clock_i);
            if (freq_trim_o === 1'b1) k++;
        end
        @(posedge clock_i);
    endtask : count_trims
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    initial begin
        map_a = '{CTRL_ADDR, PHASE_ADDR, NS_HI_ADDR, NS_LO_ADDR, SEC_HI_ADDR, SEC_LO_ADDR,
            RATE_HI_ADDR, RATE_LO_ADDR};
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        for (int i = 0; i < 8; i++) rdc(map_a[i], 16'h0000);
        v = rnd();
        wr(16'h0510, v[15:0]);
        rdc(16'h0510, 16'h0000);
        wr(CTRL_ADDR, 16'h7f80);
        rdc(CTRL_ADDR, 16'h0000);
        eph = 3'(rnd() % 5);
        esec = rnd();
        ens = rnd() % NS_PER_SEC;
        set_time(eph, esec, ens);
        wr(CTRL_ADDR, 16'h0008);
        rdc(CTRL_ADDR, 16'h0000);
        chk_rtc(esec, ens, eph);
        for (int i = 0; i < 8; i++) begin
            dsec = rnd();
            dns = (i < 2) ? NS_PER_SEC - 32'h1 : rnd() % NS_PER_SEC;
            set_time(eph, dsec, dns);
            wr(CTRL_ADDR, i[0] ? 16'h0040 : 16'h0060);
            rdc(CTRL_ADDR, i[0] ? 16'h0000 : 16'h0020);
            {esec, ens} = step_calc(esec, ens, dsec, dns, !i[0]);
            chk_rtc(esec, ens, eph);
        end
        set_time(3'((eph + 3'h1) % 5), rnd(), rnd() % NS_PER_SEC);
        wr(CTRL_ADDR, 16'h0010);
        rdc(CTRL_ADDR, 16'h0000);
        rdc(PHASE_ADDR, {13'h0, eph});
        rdc(NS_HI_ADDR, ens[31:16]);
        rdc(NS_LO_ADDR, ens[15:0]);
        rdc(SEC_HI_ADDR, esec[31:16]);
        rdc(SEC_LO_ADDR, esec[15:0]);
        for (int i = 5; i < 8; i++) begin
            wr(PHASE_ADDR, 16'(i));
            rdc(PHASE_ADDR, {13'h0, eph});
        end
        wr(CTRL_ADDR, 16'h0001);
        rdc(CTRL_ADDR, 16'h0000);
        chk_rtc(32'h0, 32'h0, eph);
        wr(CTRL_ADDR, 16'h0002);
        repeat (40) @(posedge clock_i);
        wr(CTRL_ADDR, 16'h0000);
        @(negedge clock_i);
        ens = rtc_ns_o;
        check(ens, 32'h0000_0190);
        repeat (8) @(negedge clock_i);
        check(rtc_ns_o, ens);
        @(posedge clock_i);
        for (int d = 1; d >= 0; d--) begin
            v = rnd();
            wr(RATE_LO_ADDR, v[15:0] | 16'hff00);
            wr(RATE_HI_ADDR, {d[0], 15'h3fff});
            wr(CTRL_ADDR, 16'h0006);
            rdc(CTRL_ADDR, 16'h0006);
            count_trims(n);
            check(32'(n > 8), 32'h1);
            check(freq_trim_dir_o, 32'(d));
        end
        wr(CTRL_ADDR, 16'h8006);
        count_trims(n);
        check(32'(n), 32'h0);
        check(freq_follow_disable_o, 32'h1);
        srst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        srst_i <= 1'b0;
        chk_rtc(32'h0, 32'h0, 3'h0);
        check(freq_follow_disable_o, 32'h0);
        rdc(CTRL_ADDR, 16'h0000);
        print_verdict();
    end
endmodule : tb
